// *** srs_gain_mem.sv ***
// two sets of three controller gains, one write port, registered read
// assumes at most one write per cycle
`timescale 1ns/1ps
`default_nettype none
module srs_gain_mem
  import srs_pkg::*;
(
  // clock
  input wire logic core_clk,
  // write port
  input wire logic wrEn,
  input wire logic [2:0] wrAddr,
  input wire logic [15:0] wrData,
  // read port
  input wire logic [2:0] rdAddr,
  output logic [15:0] rdData
);
  logic [15:0] mem [0:7];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// *** srs_panel_model.sv ***
// operator panel side: measured temperature and controller output
// assumes the bench sets the wanted levels; the path adds one cycle
`timescale 1ns/1ps
`default_nettype none
module srs_panel_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wanted levels
  input wire logic signed [15:0] tempSet,
  input wire logic [10:0] pctSet,
  // to the sequencer
  output logic signed [15:0] pvTemp,
  output logic [10:0] controllerOutputPercent
);
  // registered like a sampled converter, so values move only at edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pvTemp <= 16'sh0000;
      controllerOutputPercent <= 11'h000;
    end else begin
      pvTemp <= tempSet;
      controllerOutputPercent <= pctSet;
    end
  end
endmodule
`default_nettype wire

// *** srs_pkg.sv ***
// constants, field layouts and state types for the setpoint ramp sequencer
// assumes a 40 MHz core clock and temperatures in signed tenths of a degree
package srs_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_RAMP = 8'h08;
  localparam logic [7:0] REG_SLOPE = 8'h0c;
  localparam logic [7:0] REG_TRIG = 8'h10;
  localparam logic [7:0] REG_END = 8'h14;
  localparam logic [7:0] REG_COOL = 8'h18;
  localparam logic [7:0] REG_COOLTH = 8'h1c;
  localparam logic [7:0] REG_OUTLIM = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_WORKSP = 8'h28;
  localparam logic [7:0] REG_OUTPCT = 8'h2c;
  localparam logic [7:0] REG_GAIN0 = 8'h30;
  localparam logic [7:0] REG_GAIN5 = 8'h44;

  // command register bits (write only, self clearing)
  localparam int CMD_OPERATE = 0;
  localparam int CMD_STANDBY = 1;
  localparam int CMD_HOLD = 2;
  localparam int CMD_SLOPE = 3;
  localparam int CMD_AT_START = 4;
  localparam int CMD_AT_ABORT = 5;

  // field positions
  localparam int RATE_W = 14;
  localparam int UNIT_LSB = 16;
  localparam int ROUTE_LSB = 18;
  localparam int COOL_NUM_LSB = 2;
  localparam int COOL_LINK_BIT = 5;
  localparam int NUM_RELAYS = 8;

  // encodings
  localparam logic [1:0] UNIT_SEC = 2'h0;
  localparam logic [1:0] UNIT_MIN = 2'h1;
  localparam logic [1:0] COOL_OFF = 2'h0;
  localparam logic [1:0] COOL_ON = 2'h1;
  localparam logic [1:0] COOL_AUTO = 2'h2;
  localparam logic [1:0] ROUTE_ANA1 = 2'h2;
  localparam logic [1:0] ROUTE_ANA2 = 2'h3;

  // ranges in tenths
  localparam logic [13:0] RAMP_RATE_MAX = 14'h2710;
  localparam logic signed [7:0] SLOPE_MAX = 8'sh32;
  localparam logic [10:0] PCT_FULL = 11'h3e8;
  localparam logic signed [15:0] TEMP_TOP = 16'sh7fff;
  localparam logic signed [15:0] TEMP_BOT = -16'sh7fff;

  // reset values
  localparam logic signed [15:0] RST_TEMP = 16'sh0000;
  localparam logic [13:0] RST_RATE = 14'h0000;

  // timing: base tick of 100 us, one step of a tenth per divisor overflow
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICKS_SEC = 1000000000 / TICK_NS;
  localparam logic [25:0] DIV_SEC = 26'(TICKS_SEC);
  localparam logic [25:0] DIV_MIN = 26'(TICKS_SEC * 60);
  localparam logic [25:0] DIV_HOUR = 26'(TICKS_SEC * 3600);
  localparam logic [6:0] AT_SUB_TICKS = 7'h64;

  typedef enum logic [2:0] {stStandby, stRamp, stHold, stSlopeHold, stSlopeRun} srs_state_t;
  typedef enum logic [2:0] {atIdle, atRise, atFall, atRise2, atWrite} srs_at_t;

endpackage

// *** srs_ramp_if.sv ***
// signals between the sequencer and one rate-limited stepper
// assumes the stepper owns value and the sequencer owns everything else
`timescale 1ns/1ps
`default_nettype none
interface srs_ramp_if;
  logic tick;
  logic [13:0] rate;
  logic [25:0] divisor;
  logic signed [15:0] target;
  logic load;
  logic signed [15:0] loadVal;
  logic freeze;
  logic signed [15:0] value;
  modport ctrl (output tick, rate, divisor, target, load, loadVal, freeze, input value);
  modport step (input tick, rate, divisor, target, load, loadVal, freeze, output value);
endinterface
`default_nettype wire

// *** srs_ramp_step.sv ***
// rate-limited stepper: moves value one tenth toward target per divisor overflow
// assumes tick is a one-cycle pulse from the sequencer's divider
`timescale 1ns/1ps
`default_nettype none
module srs_ramp_step
  import srs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control side
  srs_ramp_if.step rp
);
  logic [25:0] acc_r;
  wire [26:0] accSum = {1'b0, acc_r} + {13'h0000, rp.rate};
  wire stepDue = accSum >= {1'b0, rp.divisor};
  wire goUp = rp.value < rp.target;
  wire atTarget = rp.value == rp.target;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 26'h0000000;
      rp.value <= RST_TEMP;
    end else if (rp.load) begin
      acc_r <= 26'h0000000;
      rp.value <= rp.loadVal;
    end else if (atTarget) begin
      acc_r <= 26'h0000000;
    end else if (rp.tick && !rp.freeze) begin
      if (rp.rate == RST_RATE) begin
        rp.value <= rp.target;
      end else if (stepDue) begin
        // single-tenth steps can never pass the target
        acc_r <= accSum[25:0] - rp.divisor;
        rp.value <= goUp ? rp.value + 16'sh0001 : rp.value - 16'sh0001;
      end else begin
        acc_r <= accSum[25:0];
      end
    end
  end
endmodule
`default_nettype wire

// *** srs_seq_assertions.sv ***
// port checker for the ramp sequencer
// assumes one-cycle bus strobes on core_clk
`timescale 1ns/1ps
`default_nettype none
module srs_seq_assertions
  import srs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWe,
  input wire logic busRe,
  input wire logic [31:0] busRdata,
  // process and outputs
  input wire logic signed [15:0] pvTemp,
  input wire logic signed [15:0] workingSetpoint,
  input wire logic [NUM_RELAYS-1:0] coolRelayDrive,
  input wire logic [9:0] analogChannelOneLevel,
  input wire logic slopeRegulationMode
);
  logic [5:0] cool_r;
  logic signed [15:0] thr_r;
  logic [19:0] lim_r;
  logic [13:0] rate_r;
  logic idle_r;
  wire cmdWr = busWe && busAddr == REG_CMD;
  wire [3:0] coolRep = cool_r[5:2];
  wire [7:0] hot = cool_r[COOL_LINK_BIT] ? 8'h01 << cool_r[4:2] : 8'h00;
  wire [9:0] ch1 = analogChannelOneLevel;
  // mirror of the configuration, rebuilt from bus writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cool_r <= '0;
      thr_r <= '0;
      lim_r <= '0;
      rate_r <= '0;
      idle_r <= 1'b1;
    end else if (busWe) begin
      if (busAddr == REG_COOL) cool_r <= busWdata[5:0];
      if (busAddr == REG_COOLTH) thr_r <= busWdata[15:0];
      if (busAddr == REG_OUTLIM) lim_r <= busWdata[19:0];
      if (busAddr == REG_RAMP) rate_r <= busWdata[13:0];
      if (cmdWr && busWdata[CMD_STANDBY]) idle_r <= 1'b1;
      else if (cmdWr && busWdata[CMD_OPERATE]) idle_r <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // relay drive lags its inputs by two flops, so they must hold for two cycles
  property p_cool_off;
    cool_r[1:0] != COOL_ON && cool_r[1:0] != COOL_AUTO && $stable(cool_r) && cool_r == $past(cool_r, 2)
      |-> coolRelayDrive == 8'h00;
  endproperty
  a_cool_off: assert property (p_cool_off) else $error("relay on in forced-off mode");
  property p_cool_on;
    cool_r[1:0] == COOL_ON && $stable(cool_r) && cool_r == $past(cool_r, 2) |-> coolRelayDrive == hot;
  endproperty
  a_cool_on: assert property (p_cool_on) else $error("relay wrong in forced-on mode");
  property p_cool_auto;
    cool_r[1:0] == COOL_AUTO && $stable(cool_r) && cool_r == $past(cool_r, 2) && thr_r == $past(thr_r, 2)
      && workingSetpoint == $past(workingSetpoint, 2)
      |-> coolRelayDrive == (workingSetpoint >= thr_r ? hot : 8'h00);
  endproperty
  a_cool_auto: assert property (p_cool_auto) else $error("relay wrong in auto mode");
  property p_cool_report;
    busRe && busAddr == REG_STATUS |=> busRdata[11:8] == $past(coolRep);
  endproperty
  a_cool_report: assert property (p_cool_report) else $error("relay number misreported");
  // two cycles of stable setup so a route switch may settle first
  property p_out_limit;
    lim_r[19:18] == ROUTE_ANA1 && lim_r[13:0] != '0 && $stable(lim_r) && lim_r == $past(lim_r, 2)
      |-> ch1 <= $past(ch1) + 10'h001 && $past(ch1) <= ch1 + 10'h001;
  endproperty
  a_out_limit: assert property (p_out_limit) else $error("limited output jumped");
  property p_operate_load;
    cmdWr && busWdata[CMD_OPERATE] && idle_r |-> ##[1:2] workingSetpoint == pvTemp;
  endproperty
  a_operate_load: assert property (p_operate_load) else $error("operate did not load temperature");
  property p_slope_enter;
    cmdWr && busWdata[CMD_SLOPE] && !busWdata[CMD_STANDBY] && !idle_r |-> ##[1:2] slopeRegulationMode;
  endproperty
  a_slope_enter: assert property (p_slope_enter) else $error("slope mode not entered");
  property p_ramp_step;
    rate_r != '0 && $stable(rate_r) && !$past(cmdWr) && !$past(cmdWr, 2)
      |-> workingSetpoint <= $past(workingSetpoint) + 16'sh0001 && $past(workingSetpoint) <= workingSetpoint + 16'sh0001;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("setpoint moved too far in one step");
endmodule
bind srs_sequencer srs_seq_assertions srs_seq_assertions_i (.core_clk(core_clk), .rst_n(rst_n), .busAddr(busAddr),
  .busWdata(busWdata), .busWe(busWe), .busRe(busRe), .busRdata(busRdata), .pvTemp(pvTemp),
  .workingSetpoint(workingSetpoint), .coolRelayDrive(coolRelayDrive), .analogChannelOneLevel(analogChannelOneLevel),
  .slopeRegulationMode(slopeRegulationMode));
`default_nettype wire

// *** srs_sequencer.sv ***
// setpoint ramp sequencer: cooling relay, output limiter, setpoint and slope ramps
// assumes single-cycle bus strobes and a process temperature synchronous to core_clk
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module srs_sequencer
  import srs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWe,
  input wire logic busRe,
  output logic [31:0] busRdata,
  // process side
  input wire logic signed [15:0] pvTemp,
  input wire logic [10:0] controllerOutputPercent,
  // outputs
  output logic signed [15:0] workingSetpoint,
  output logic [NUM_RELAYS-1:0] coolRelayDrive,
  output logic [9:0] analogChannelOneLevel,
  output logic [9:0] analogChannelTwoLevel,
  output logic [9:0] directOutputLevel,
  output logic [15:0] gainP,
  output logic [15:0] gainI,
  output logic [15:0] gainD,
  output logic slopeRegulationMode,
  output logic autotuneBusy
);
  srs_state_t state_r, state_nxt;
  srs_at_t at_r;
  logic [11:0] tickCnt_r;
  logic tick_r;
  logic signed [15:0] targetSp_r, trigTemp_r, endTemp_r, coolTh_r;
  logic [13:0] rampRate_r, outRate_r;
  logic [1:0] rampUnit_r, outUnit_r, route_r, coolMode_r;
  logic [2:0] coolNum_r;
  logic coolLinked_r, coolOn_r, trigUp_r;
  logic signed [7:0] slope_r;
  logic [1:0] gIdx_r, gIdxPrev_r;
  logic [6:0] atSub_r;
  logic [15:0] atPer_r, atMin_r, atMax_r;
  logic [1:0] atWr_r;
  logic [15:0] gainRd;

  srs_ramp_if spBus ();
  srs_ramp_if outBus ();

  // decode
  wire wrCmd = busWe && busAddr == REG_CMD;
  wire cmdOperate = wrCmd && busWdata[CMD_OPERATE];
  wire cmdStandby = wrCmd && busWdata[CMD_STANDBY];
  wire cmdHold = wrCmd && busWdata[CMD_HOLD];
  wire cmdSlope = wrCmd && busWdata[CMD_SLOPE];
  wire cmdAtStart = wrCmd && busWdata[CMD_AT_START];
  wire cmdAtAbort = wrCmd && busWdata[CMD_AT_ABORT];
  wire wrGain = busWe && busAddr >= REG_GAIN0 && busAddr <= REG_GAIN5 && busAddr[1:0] == 2'h0;
  wire [7:0] gainOff = busAddr - REG_GAIN0;
  // words 3..5 are the slope set, which lives at entries 4..6
  wire [2:0] gainWord = gainOff[4:2];
  wire [2:0] gainIdx = gainWord < 3'h3 ? gainWord : gainWord + 3'h1;
  wire [13:0] wRate = busWdata[13:0] > RAMP_RATE_MAX ? RAMP_RATE_MAX : busWdata[13:0];
  wire signed [7:0] wSlopeIn = busWdata[7:0];
  wire signed [7:0] wSlope = wSlopeIn > SLOPE_MAX ? SLOPE_MAX :
    (wSlopeIn < -SLOPE_MAX ? -SLOPE_MAX : wSlopeIn);

  // mode helpers
  wire slopeActive = state_r == stSlopeHold || state_r == stSlopeRun;
  wire running = state_r == stRamp || state_r == stSlopeRun;
  wire [10:0] pidClamped = controllerOutputPercent > PCT_FULL ? PCT_FULL : controllerOutputPercent;
  wire [10:0] atForced = (at_r == atRise || at_r == atRise2) ? PCT_FULL : 11'h000;
  wire [10:0] ctrlPct = at_r == atIdle ? pidClamped : atForced;
  wire limitOn = route_r == ROUTE_ANA1 || route_r == ROUTE_ANA2;
  wire [7:0] slopeMag = slope_r[7] ? 8'(-slope_r) : 8'(slope_r);
  wire trigHit = trigUp_r ? pvTemp >= trigTemp_r : pvTemp <= trigTemp_r;
  wire signed [15:0] atSpan = signed'(atMax_r) - signed'(atMin_r);

  function automatic logic [25:0] unitDiv(input logic [1:0] u);
    unitDiv = u == UNIT_SEC ? DIV_SEC : (u == UNIT_MIN ? DIV_MIN : DIV_HOUR);
  endfunction

  // setpoint stepper
  assign spBus.tick = tick_r;
  assign spBus.rate = state_r == stSlopeRun ? {6'h00, slopeMag} : rampRate_r;
  assign spBus.divisor = state_r == stSlopeRun ? DIV_SEC : unitDiv(rampUnit_r);
  assign spBus.target = state_r == stSlopeRun ? (slope_r[7] ? TEMP_BOT : TEMP_TOP) : targetSp_r;
  assign spBus.load = (state_r == stStandby && cmdOperate) || (state_r == stSlopeRun && cmdHold);
  assign spBus.loadVal = pvTemp;
  assign spBus.freeze = !running || (state_r == stSlopeRun && slope_r == 8'sh00);
  assign workingSetpoint = spBus.value;

  // output limiter stepper, bypassed when not routed to an analog channel
  assign outBus.tick = tick_r;
  assign outBus.rate = outRate_r;
  assign outBus.divisor = unitDiv(outUnit_r);
  assign outBus.target = signed'({5'h00, ctrlPct});
  assign outBus.load = !limitOn;
  assign outBus.loadVal = signed'({5'h00, ctrlPct});
  assign outBus.freeze = 1'b0;

  srs_ramp_step spStep (.core_clk(core_clk), .rst_n(rst_n), .rp(spBus.step));
  srs_ramp_step outStep (.core_clk(core_clk), .rst_n(rst_n), .rp(outBus.step));

  // gain memory: autotune owns the write port while it stores results
  wire atWriting = at_r == atWrite;
  wire [15:0] atWord = atWr_r == 2'h0 ? 16'(atSpan <<< 1) : (atWr_r == 2'h1 ? atPer_r >> 1 : atPer_r >> 3);
  srs_gain_mem gains (
    .core_clk(core_clk),
    .wrEn(atWriting || wrGain),
    .wrAddr(atWriting ? {1'b0, atWr_r} : gainIdx),
    .wrData(atWriting ? atWord : busWdata[15:0]),
    .rdAddr({slopeActive, gIdx_r}),
    .rdData(gainRd)
  );

  // sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      stStandby: if (cmdOperate) state_nxt = stRamp;
      stRamp: if (cmdHold) state_nxt = stHold;
      stHold: if (cmdHold) state_nxt = stRamp;
      stSlopeHold: if (cmdHold) state_nxt = stSlopeRun;
      stSlopeRun: begin
        if (trigHit) state_nxt = stRamp;
        else if (cmdHold) state_nxt = stSlopeHold;
      end
      default: state_nxt = stStandby;
    endcase
    if (cmdSlope && state_r != stStandby) state_nxt = stSlopeHold;
    if (cmdStandby) state_nxt = stStandby;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 12'h000;
      tick_r <= 1'b0;
      state_r <= stStandby;
    end else begin
      tick_r <= tickCnt_r == 12'(TICK_CYC - 1);
      tickCnt_r <= tickCnt_r == 12'(TICK_CYC - 1) ? 12'h000 : tickCnt_r + 12'h001;
      state_r <= state_nxt;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      targetSp_r <= RST_TEMP;
      trigTemp_r <= RST_TEMP;
      endTemp_r <= RST_TEMP;
      coolTh_r <= RST_TEMP;
      rampRate_r <= RST_RATE;
      outRate_r <= RST_RATE;
      rampUnit_r <= UNIT_SEC;
      outUnit_r <= UNIT_SEC;
      route_r <= 2'h0;
      coolMode_r <= COOL_OFF;
      coolNum_r <= 3'h0;
      coolLinked_r <= 1'b0;
      slope_r <= 8'sh00;
      trigUp_r <= 1'b0;
    end else begin
      if (state_r == stSlopeRun && trigHit) targetSp_r <= endTemp_r;
      else if (busWe && busAddr == REG_TARGET) targetSp_r <= busWdata[15:0];
      if (busWe && busAddr == REG_RAMP) begin
        rampRate_r <= wRate;
        rampUnit_r <= busWdata[UNIT_LSB+:2];
      end
      if (busWe && busAddr == REG_SLOPE) slope_r <= wSlope;
      if (busWe && busAddr == REG_TRIG) trigTemp_r <= busWdata[15:0];
      if (busWe && busAddr == REG_END) endTemp_r <= busWdata[15:0];
      if (busWe && busAddr == REG_COOL) begin
        coolMode_r <= busWdata[1:0];
        coolNum_r <= busWdata[COOL_NUM_LSB+:3];
        coolLinked_r <= busWdata[COOL_LINK_BIT];
      end
      if (busWe && busAddr == REG_COOLTH) coolTh_r <= busWdata[15:0];
      if (busWe && busAddr == REG_OUTLIM) begin
        outRate_r <= busWdata[13:0] > 14'(PCT_FULL) ? 14'(PCT_FULL) : busWdata[13:0];
        outUnit_r <= busWdata[UNIT_LSB+:2];
        route_r <= busWdata[ROUTE_LSB+:2];
      end
      // crossing direction fixed when the slope run starts
      if (state_r == stSlopeHold && cmdHold) trigUp_r <= pvTemp < trigTemp_r;
    end
  end

  // cooling relay and output routing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coolOn_r <= 1'b0;
      analogChannelOneLevel <= 10'h000;
      analogChannelTwoLevel <= 10'h000;
      directOutputLevel <= 10'h000;
    end else begin
      case (coolMode_r)
        COOL_ON: coolOn_r <= 1'b1;
        COOL_AUTO: coolOn_r <= spBus.value >= coolTh_r;
        default: coolOn_r <= 1'b0;
      endcase
      analogChannelOneLevel <= route_r == ROUTE_ANA1 ? outBus.value[9:0] : 10'h000;
      analogChannelTwoLevel <= route_r == ROUTE_ANA2 ? outBus.value[9:0] : 10'h000;
      directOutputLevel <= limitOn ? 10'h000 : ctrlPct[9:0];
    end
  end

  genvar r;
  generate
    for (r = 0; r < NUM_RELAYS; r++) begin : relayBit
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) coolRelayDrive[r] <= 1'b0;
        else coolRelayDrive[r] <= coolLinked_r && coolNum_r == 3'(r) && coolOn_r;
      end
    end
  endgenerate

  // active gain set fetch, one word per cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gIdx_r <= 2'h0;
      gIdxPrev_r <= 2'h0;
      gainP <= 16'h0000;
      gainI <= 16'h0000;
      gainD <= 16'h0000;
      slopeRegulationMode <= 1'b0;
    end else begin
      gIdx_r <= gIdx_r == 2'h2 ? 2'h0 : gIdx_r + 2'h1;
      gIdxPrev_r <= gIdx_r;
      if (gIdxPrev_r == 2'h0) gainP <= gainRd;
      if (gIdxPrev_r == 2'h1) gainI <= gainRd;
      if (gIdxPrev_r == 2'h2) gainD <= gainRd;
      slopeRegulationMode <= slopeActive;
    end
  end

  // relay autotune: one full oscillation around the setpoint, then store gains
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      at_r <= atIdle;
      atSub_r <= 7'h00;
      atPer_r <= 16'h0000;
      atMin_r <= 16'h0000;
      atMax_r <= 16'h0000;
      atWr_r <= 2'h0;
      autotuneBusy <= 1'b0;
    end else begin
      autotuneBusy <= at_r != atIdle;
      if (at_r != atIdle && tick_r) begin
        atSub_r <= atSub_r == AT_SUB_TICKS - 7'h01 ? 7'h00 : atSub_r + 7'h01;
        if (atSub_r == AT_SUB_TICKS - 7'h01 && atPer_r != 16'hffff) atPer_r <= atPer_r + 16'h0001;
      end
      if (at_r == atFall || at_r == atRise2) begin
        if (pvTemp > signed'(atMax_r)) atMax_r <= pvTemp;
        if (pvTemp < signed'(atMin_r)) atMin_r <= pvTemp;
      end
      case (at_r)
        atIdle: begin
          if (cmdAtStart && state_r == stRamp) begin
            at_r <= atRise;
            atWr_r <= 2'h0;
          end
        end
        atRise: begin
          if (pvTemp >= spBus.value) begin
            at_r <= atFall;
            atPer_r <= 16'h0000;
            atSub_r <= 7'h00;
            atMin_r <= pvTemp;
            atMax_r <= pvTemp;
          end
        end
        atFall: if (pvTemp < spBus.value) at_r <= atRise2;
        atRise2: if (pvTemp >= spBus.value) at_r <= atWrite;
        atWrite: begin
          atWr_r <= atWr_r + 2'h1;
          if (atWr_r == 2'h2) at_r <= atIdle;
        end
        default: at_r <= atIdle;
      endcase
      if (cmdAtAbort || state_r != stRamp) at_r <= atIdle;
    end
  end

  // read data, present only in the cycle after the strobe
  wire [31:0] rdMux =
    busAddr == REG_TARGET ? {{16{targetSp_r[15]}}, targetSp_r} :
    busAddr == REG_RAMP ? {14'h0000, rampUnit_r, 2'h0, rampRate_r} :
    busAddr == REG_SLOPE ? {{24{slope_r[7]}}, slope_r} :
    busAddr == REG_TRIG ? {{16{trigTemp_r[15]}}, trigTemp_r} :
    busAddr == REG_END ? {{16{endTemp_r[15]}}, endTemp_r} :
    busAddr == REG_COOL ? {26'h0000000, coolLinked_r, coolNum_r, coolMode_r} :
    busAddr == REG_COOLTH ? {{16{coolTh_r[15]}}, coolTh_r} :
    busAddr == REG_OUTLIM ? {12'h000, route_r, outUnit_r, 2'h0, outRate_r} :
    busAddr == REG_STATUS ? {20'h00000, coolLinked_r, coolNum_r, coolOn_r, autotuneBusy, slopeActive,
      1'b0, 1'b0, state_r} :
    busAddr == REG_WORKSP ? {{16{spBus.value[15]}}, spBus.value} :
    busAddr == REG_OUTPCT ? {16'h0000, outBus.value} :
    32'h00000000;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busRdata <= 32'h00000000;
    else busRdata <= busRe ? rdMux : 32'h00000000;
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the ramp sequencer
// assumes the panel model beside it and one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import srs_pkg::*;
;
  typedef struct packed {logic [7:0] cool; logic [15:0] thr; logic [7:0] drive; logic [3:0] stat;} srs_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [31:0] busWdata = 32'h0;
  logic busWe = 1'b0;
  logic busRe = 1'b0;
  logic signed [15:0] tempSet = 16'sh0000;
  logic [10:0] pctSet = 11'h000;
  logic [31:0] busRdata, rdv;
  logic signed [15:0] pvTemp, workingSetpoint, heldSp;
  logic [10:0] controllerOutputPercent;
  logic [7:0] coolRelayDrive;
  logic [9:0] chOne, chTwo, direct;
  logic [15:0] gainP, gainI, gainD;
  logic slopeMode, busy;
  int errorCnt = 0;
  int numChecks = 0;
  srs_row_t rows [7] = '{'{8'h2c, 16'h0000, 8'h00, 4'hb}, '{8'h2d, 16'h0000, 8'h08, 4'hb},
    '{8'h19, 16'h0000, 8'h00, 4'h6}, '{8'h36, 16'hfffb, 8'h20, 4'hd}, '{8'h36, 16'h0000, 8'h20, 4'hd},
    '{8'h36, 16'h0001, 8'h00, 4'hd}, '{8'h3f, 16'h0000, 8'h00, 4'hf}};
  always #12.5 core_clk = ~core_clk;
  srs_panel_model srs_panel_model_i (.core_clk(core_clk), .rst_n(rst_n), .tempSet(tempSet), .pctSet(pctSet),
    .pvTemp(pvTemp), .controllerOutputPercent(controllerOutputPercent));
  srs_sequencer srs_sequencer_i (.core_clk(core_clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata),
    .busWe(busWe), .busRe(busRe), .busRdata(busRdata), .pvTemp(pvTemp),
    .controllerOutputPercent(controllerOutputPercent), .workingSetpoint(workingSetpoint),
    .coolRelayDrive(coolRelayDrive), .analogChannelOneLevel(chOne), .analogChannelTwoLevel(chTwo),
    .directOutputLevel(direct), .gainP(gainP), .gainI(gainI), .gainD(gainD),
    .slopeRegulationMode(slopeMode), .autotuneBusy(busy));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busAddr <= a;
    busWdata <= d;
    busWe <= 1'b1;
    @(posedge core_clk);
    busWe <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    busAddr <= a;
    busRe <= 1'b1;
    @(posedge core_clk);
    busRe <= 1'b0;
    #1 d = busRdata;
    @(posedge core_clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic waitSp(input logic signed [15:0] v, input int lim);
    int n;
    n = 0;
    while (workingSetpoint !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk("workingSetpoint", v, workingSetpoint);
  endtask
  task automatic giveVerdict();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    errorCnt++;
    giveVerdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(1);
    chk("workingSetpoint", 32'h0, workingSetpoint);
    rd(8'hfc, rdv);
    chk("unmapped read", 32'h0, rdv);
    foreach (rows[i]) begin
      wr(REG_COOLTH, 32'(rows[i].thr));
      wr(REG_COOL, 32'(rows[i].cool));
      cyc(2);
      chk("coolRelayDrive", 32'(rows[i].drive), coolRelayDrive);
      rd(REG_STATUS, rdv);
      chk("status relay", 32'(rows[i].stat), rdv[11:8]);
    end
    // gain memory has no reset, so all six words go in first
    for (int k = 0; k < 6; k++) begin
      wr(REG_GAIN0 + 8'(4 * k), 32'h1000 + 32'(k));
    end
    cyc(4);
    chk("gainP", 32'h1000, gainP);
    chk("gainD", 32'h1002, gainD);
    tempSet <= 16'sh0064;
    wr(REG_RAMP, {14'h0, UNIT_SEC, 2'h0, RAMP_RATE_MAX});
    wr(REG_TARGET, 32'h61);
    wr(REG_CMD, 32'h1);
    chk("workingSetpoint", 32'h64, workingSetpoint);
    waitSp(16'sh0061, 5 * TICK_CYC);
    cyc(TICK_CYC + 10);
    chk("workingSetpoint", 32'h61, workingSetpoint);
    wr(REG_TARGET, 32'h67);
    waitSp(16'sh0062, 2 * TICK_CYC);
    wr(REG_CMD, 32'h4);
    heldSp = workingSetpoint;
    cyc(2 * TICK_CYC);
    chk("held setpoint", 32'(heldSp), workingSetpoint);
    wr(REG_CMD, 32'h4);
    waitSp(16'sh0067, 6 * TICK_CYC);
    rd(REG_WORKSP, rdv);
    chk("setpoint read", 32'h67, rdv);
    wr(REG_RAMP, 32'h00023fff);
    rd(REG_RAMP, rdv);
    chk("ramp clamp", 32'h00022710, rdv);
    wr(REG_RAMP, 32'h0);
    wr(REG_SLOPE, 32'h7f);
    rd(REG_SLOPE, rdv);
    chk("slope clamp", 32'h32, rdv);
    wr(REG_TRIG, 32'hc8);
    wr(REG_END, 32'h96);
    wr(REG_CMD, 32'h8);
    cyc(6);
    chk("slope mode", 32'h1, slopeMode);
    chk("workingSetpoint", 32'h67, workingSetpoint);
    chk("gainP", 32'h1003, gainP);
    tempSet <= 16'sh0078;
    wr(REG_CMD, 32'h4);
    rd(REG_STATUS, rdv);
    chk("state", 32'h4, rdv[2:0]);
    wr(REG_CMD, 32'h4);
    cyc(1);
    chk("workingSetpoint", 32'h78, workingSetpoint);
    wr(REG_CMD, 32'h4);
    tempSet <= 16'sh00fa;
    waitSp(16'sh0096, 2 * TICK_CYC);
    cyc(4);
    chk("slope mode", 32'h0, slopeMode);
    chk("gainP", 32'h1000, gainP);
    // autotune from the ramp state: one swing down and back up
    wr(REG_CMD, 32'h10);
    tempSet <= 16'sh0050;
    cyc(2);
    chk("autotune busy", 32'h1, busy);
    tempSet <= 16'sh00fa;
    cyc(10);
    chk("gainP", 32'h0154, gainP);
    chk("gainI", 32'h0, gainI);
    chk("autotune busy", 32'h0, busy);
    wr(REG_OUTLIM, {12'h0, ROUTE_ANA1, UNIT_SEC, 2'h0, 14'h03e8});
    pctSet <= 11'h5dc;
    cyc(3);
    chk("channel one", 32'h0, chOne);
    chk("channel two", 32'h0, chTwo);
    wr(REG_OUTLIM, 32'h0);
    cyc(2);
    chk("direct level", 32'h3e8, direct);
    wr(REG_OUTLIM, {12'h0, ROUTE_ANA2, 18'h0});
    cyc(TICK_CYC + 10);
    chk("channel two", 32'h3e8, chTwo);
    giveVerdict();
  end
endmodule
`default_nettype wire
